// ---- include/bbm_params.svh ----
// Constants for the boot and base mapping block
`ifndef BBM_PARAMS_SVH
`define BBM_PARAMS_SVH
// Fixed absolute addresses of base and base-enable registers
`define BBM_MBR_ADDR 32'h0003_ff00
`define BBM_MBRE_ADDR 32'h0003_ff04
// Relocatable region is 8 Kbyte: base compares bits 31..13
`define BBM_BLK_LSB 13
`define BBM_MBR_RST 32'h0000_0000
`define BBM_MBRE_RST 32'h0000_0001
`define BBM_MBR_V_BIT 0
// Register offsets inside the 8-Kbyte region
`define BBM_OFS_RCR 13'h1000
`define BBM_OFS_SYN 13'h1004
`define BBM_OFS_PA 13'h1008
`define BBM_OFS_GM 13'h100c
`define BBM_OFS_BSO 13'h1010
`define BBM_OFS_BSB 13'h1014
`define BBM_OFS_CMD 13'h1018
// Dual-port RAM: 1762 system bytes then 768 parameter bytes
`define BBM_SYS_BYTES 1762
`define BBM_PRM_BYTES 768
`define BBM_DPR_BYTES 2530
`define BBM_CH_BASE 12'h6e2
`define BBM_CH_LAST 12'h2ff
// Boot vector locations
`define BBM_SP_ADDR 32'h0000_0000
`define BBM_PC_ADDR 32'h0000_0004
// Function codes
`define BBM_FC_SUP_DATA 3'h5
`define BBM_FC_SUP_PROG 3'h6
// Boot select defaults and field positions
`define BBM_BOOT_WAIT_RST 4'hf
`define BBM_BSB_RST 32'h0000_0000
`define BBM_BSO_RST 32'h0000_0000
`define BBM_GM_RST 32'h0000_0000
`define BBM_BS_V_BIT 0
`define BBM_AM_LSB 11
// Synthesizer control
`define BBM_SYN_LOCK 16'h8000
`define BBM_SYN_RST 16'h0000
// Pin assignment
`define BBM_PA_WE_BIT 7
`define BBM_PA_RST 16'h0000
// Reset cause
`define BBM_RCR_POR_BIT 0
`define BBM_RCR_RST 8'h01
// Command register
`define BBM_CMD_FLG_BIT 0
`define BBM_CMD_OP_LSB 8
`define BBM_CMD_OP_RESET 4'h0
`endif

// ---- include/bbm_pkg.sv ----
// Types shared by the boot and base mapping block
package bbm_pkg;
   // Main sequencer states
   typedef enum logic [2:0] {
      BBM_S_SP, BBM_S_SPW, BBM_S_PC, BBM_S_PCW,
      BBM_S_IDLE, BBM_S_INT, BBM_S_EXT, BBM_S_EXTW
   } bbm_state_t;
   // Core access request
   typedef struct packed {
      logic valid;
      logic wr;
      logic fetch;
      logic [31:0] addr;
      logic [31:0] wdata;
   } bbm_acc_t;
   // External memory request
   typedef struct packed {
      logic req;
      logic wr;
      logic [2:0] fc;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic boot_cs;
      logic [3:0] waits;
   } bbm_mem_t;
endpackage

// ---- design/bbm_dpram.sv ----
// Byte-wide dual-port RAM, contents not cleared by reset
`timescale 1ns/1ps
`default_nettype none
module bbm_dpram #(
   parameter int DEPTH = 2530,
   parameter int AW = 12
) (
   input wire logic ref_clk,
   input wire logic a_en,
   input wire logic a_we,
   input wire logic [AW-1:0] a_addr,
   input wire logic [7:0] a_wdata,
   output logic [7:0] a_rdata,
   input wire logic b_we,
   input wire logic [AW-1:0] b_addr,
   input wire logic [7:0] b_wdata
);
   // Storage, power-up contents undefined
   logic [7:0] mem [0:DEPTH-1];
   // Port A read/write, port B write only
   always_ff @(posedge ref_clk) begin
      if (a_en && a_we) begin
         mem[a_addr] <= a_wdata;
      end
      if (a_en) begin
         a_rdata <= mem[a_addr];
      end
      if (b_we) begin
         mem[b_addr] <= b_wdata;
      end
   end
endmodule
`default_nettype wire

// ---- design/bbm_boot_map.sv ----
// Boot sequencing, base relocation and early configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "bbm_params.svh"
module bbm_boot_map
   import bbm_pkg::*;
#(
   parameter int DPR_BYTES = `BBM_DPR_BYTES
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire bbm_acc_t acc,
   output logic acc_ready,
   output logic acc_done,
   output logic [31:0] acc_rdata,
   output logic acc_internal,
   output bbm_mem_t mem,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   input wire logic [7:0] rst_cause,
   input wire logic osc_exact,
   output logic core_run,
   output logic core_super,
   output logic [31:0] core_sp,
   output logic [31:0] core_pc,
   output logic [12:0] synth_factor,
   output logic synth_locked,
   output logic pin_we_sel,
   output logic cp_busy
);
   // Sequencer and access state
   bbm_state_t state_r, state_nxt;
   bbm_acc_t acc_r, acc_nxt;
   bbm_mem_t mem_r, mem_nxt;
   logic [31:0] sp_r, sp_nxt;
   logic [31:0] pc_r, pc_nxt;
   logic run_r, run_nxt;
   logic done_r, done_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic intl_r, intl_nxt;
   // Configuration registers
   logic [31:0] mbr_r, mbr_nxt;
   logic mbre_r, mbre_nxt;
   logic [7:0] rcr_r, rcr_nxt;
   logic [15:0] syn_r, syn_nxt;
   logic syn_lock_r, syn_lock_nxt;
   logic [15:0] pa_r, pa_nxt;
   logic [31:0] gm_r, gm_nxt;
   logic [31:0] bso_r, bso_nxt;
   logic [31:0] bsb_r, bsb_nxt;
   logic osc_r, osc_nxt;
   logic [12:0] fac_r, fac_nxt;
   // Channel reinit engine
   logic cp_busy_r, cp_busy_nxt;
   logic [11:0] cp_cnt_r, cp_cnt_nxt;
   // Pin synchronisers
   logic ack_m, ack_s;
   logic [31:0] dat_m, dat_s;
   logic osc_m, osc_s;
   // RAM port wiring
   logic a_en, a_we;
   logic [11:0] a_addr;
   logic [7:0] a_q;
   logic b_we;
   logic [11:0] b_addr;
   // Decoded take and write strobes, register offset
   logic take, wr_int;
   logic [12:0] ofs;

   // Address falls in relocated 8-Kbyte region
   function automatic logic blk_hit(input logic [31:0] a,
                                    input logic [31:0] base);
      blk_hit = base[`BBM_MBR_V_BIT] &&
                (a[31:`BBM_BLK_LSB] == base[31:`BBM_BLK_LSB]);
   endfunction

   // Address is internal: fixed registers or relocated region
   function automatic logic int_hit(input logic [31:0] a,
                                    input logic [31:0] base);
      int_hit = (a == `BBM_MBR_ADDR) || (a == `BBM_MBRE_ADDR) ||
                blk_hit(a, base);
   endfunction

   // Boot select match under current base/option setup
   function automatic logic bs_hit(input logic [31:0] a,
                                   input logic [31:0] bb,
                                   input logic [31:0] bo);
      logic [20:0] m;
      m = bo[31:`BBM_AM_LSB];
      if (!bb[`BBM_BS_V_BIT]) begin
         bs_hit = 1'b1;
      end else begin
         bs_hit = ((a[31:`BBM_AM_LSB] ^ bb[31:`BBM_AM_LSB]) & m) == '0;
      end
   endfunction

   // Two-flop synchronisers for pins
   always_ff @(posedge ref_clk) begin
      ack_m <= mem_ack;
      ack_s <= ack_m;
      dat_m <= mem_rdata;
      dat_s <= dat_m;
      osc_m <= osc_exact;
      osc_s <= osc_m;
   end

   assign take = (state_r == BBM_S_IDLE) && acc.valid;
   assign ofs = acc_r.addr[12:0];
   assign wr_int = (state_r == BBM_S_INT) && acc_r.wr;

   // Internal RAM: read at take, write in internal cycle
   always_comb begin
      a_en = 1'b0;
      a_we = 1'b0;
      a_addr = acc.addr[11:0];
      if (take && blk_hit(acc.addr, mbr_r)) begin
         a_en = !acc.wr;
      end
      if (wr_int && blk_hit(acc_r.addr, mbr_r) &&
          ofs < 13'(DPR_BYTES)) begin
         a_en = 1'b1;
         a_we = 1'b1;
         a_addr = acc_r.addr[11:0];
      end
   end

   // Sequencer: boot vectors, then core accesses
   always_comb begin
      state_nxt = state_r;
      acc_nxt = acc_r;
      mem_nxt = mem_r;
      sp_nxt = sp_r;
      pc_nxt = pc_r;
      run_nxt = run_r;
      done_nxt = 1'b0;
      rdata_nxt = rdata_r;
      intl_nxt = intl_r;
      case (state_r)
         BBM_S_SP: begin
            // Stack pointer from first boot location
            mem_nxt.req = 1'b1;
            mem_nxt.wr = 1'b0;
            mem_nxt.addr = `BBM_SP_ADDR;
            mem_nxt.fc = `BBM_FC_SUP_PROG;
            mem_nxt.boot_cs = 1'b1;
            mem_nxt.waits = `BBM_BOOT_WAIT_RST;
            if (mem_r.req && ack_s) begin
               sp_nxt = dat_s;
               mem_nxt.req = 1'b0;
               mem_nxt.boot_cs = 1'b0;
               state_nxt = BBM_S_SPW;
            end
         end
         BBM_S_SPW: begin
            // Wait for acknowledge release
            if (!ack_s) begin
               state_nxt = BBM_S_PC;
            end
         end
         BBM_S_PC: begin
            // Start vector from next boot location
            mem_nxt.req = 1'b1;
            mem_nxt.addr = `BBM_PC_ADDR;
            mem_nxt.boot_cs = 1'b1;
            if (mem_r.req && ack_s) begin
               pc_nxt = dat_s;
               mem_nxt.req = 1'b0;
               mem_nxt.boot_cs = 1'b0;
               state_nxt = BBM_S_PCW;
            end
         end
         BBM_S_PCW: begin
            // Release core once handshake is idle
            if (!ack_s) begin
               run_nxt = 1'b1;
               state_nxt = BBM_S_IDLE;
            end
         end
         BBM_S_IDLE: begin
            // Take a core request
            if (acc.valid) begin
               acc_nxt = acc;
               if (int_hit(acc.addr, mbr_r)) begin
                  intl_nxt = 1'b1;
                  state_nxt = BBM_S_INT;
               end else begin
                  intl_nxt = 1'b0;
                  mem_nxt.req = 1'b1;
                  mem_nxt.wr = acc.wr;
                  mem_nxt.addr = acc.addr;
                  mem_nxt.wdata = acc.wdata;
                  mem_nxt.fc = acc.fetch ? `BBM_FC_SUP_PROG
                                         : `BBM_FC_SUP_DATA;
                  mem_nxt.boot_cs = bs_hit(acc.addr, bsb_r,
                                           bso_r);
                  mem_nxt.waits = bsb_r[`BBM_BS_V_BIT] ? bso_r[3:0]
                                  : `BBM_BOOT_WAIT_RST;
                  state_nxt = BBM_S_EXT;
               end
            end
         end
         BBM_S_INT: begin
            // Internal answer: RAM byte or register
            done_nxt = 1'b1;
            rdata_nxt = 32'h0000_0000;
            if (!acc_r.wr) begin
               if (acc_r.addr == `BBM_MBR_ADDR) begin
                  rdata_nxt = mbr_r;
               end else if (acc_r.addr == `BBM_MBRE_ADDR) begin
                  rdata_nxt = {31'h0, mbre_r};
               end else if (ofs < 13'(DPR_BYTES)) begin
                  rdata_nxt = {24'h00_0000, a_q};
               end else begin
                  case (ofs)
                     `BBM_OFS_RCR: rdata_nxt = {24'h00_0000, rcr_r};
                     `BBM_OFS_SYN: rdata_nxt = {16'h0000, syn_r};
                     `BBM_OFS_PA: rdata_nxt = {16'h0000, pa_r};
                     `BBM_OFS_GM: rdata_nxt = gm_r;
                     `BBM_OFS_BSO: rdata_nxt = bso_r;
                     `BBM_OFS_BSB: rdata_nxt = bsb_r;
                     `BBM_OFS_CMD: rdata_nxt = {31'h0, cp_busy_r};
                     default: rdata_nxt = 32'h0000_0000;
                  endcase
               end
            end
            state_nxt = BBM_S_IDLE;
         end
         BBM_S_EXT: begin
            // External access until acknowledge
            if (mem_r.req && ack_s) begin
               rdata_nxt = mem_r.wr ? 32'h0000_0000 : dat_s;
               done_nxt = 1'b1;
               mem_nxt.req = 1'b0;
               mem_nxt.boot_cs = 1'b0;
               state_nxt = BBM_S_EXTW;
            end
         end
         BBM_S_EXTW: begin
            // Wait for acknowledge release
            if (!ack_s) begin
               state_nxt = BBM_S_IDLE;
            end
         end
         default: begin
            state_nxt = BBM_S_IDLE;
         end
      endcase
   end

   // Configuration register updates
   always_comb begin
      mbr_nxt = mbr_r;
      mbre_nxt = mbre_r;
      syn_nxt = syn_r;
      syn_lock_nxt = syn_lock_r;
      pa_nxt = pa_r;
      gm_nxt = gm_r;
      bso_nxt = bso_r;
      bsb_nxt = bsb_r;
      osc_nxt = sys_rst ? osc_s : osc_r;
      // Write-one clears, a new cause wins over the clear
      rcr_nxt = rcr_r;
      if (wr_int && ofs == `BBM_OFS_RCR && blk_hit(acc_r.addr, mbr_r)) begin
         rcr_nxt = rcr_r & ~acc_r.wdata[7:0];
      end
      if (rst_cause[`BBM_RCR_POR_BIT]) begin
         rcr_nxt = rst_cause;
      end else begin
         rcr_nxt = rcr_nxt | rst_cause;
      end
      if (wr_int && acc_r.addr == `BBM_MBR_ADDR && mbre_r) begin
         mbr_nxt = acc_r.wdata;
      end
      if (wr_int && acc_r.addr == `BBM_MBRE_ADDR) begin
         mbre_nxt = acc_r.wdata[0];
      end
      if (wr_int && blk_hit(acc_r.addr, mbr_r)) begin
         case (ofs)
            `BBM_OFS_SYN: begin
               if (!syn_lock_r) begin
                  syn_nxt = acc_r.wdata[15:0];
                  if (acc_r.wdata[15:0] == `BBM_SYN_LOCK) begin
                     syn_lock_nxt = 1'b1;
                  end
               end
            end
            `BBM_OFS_PA: pa_nxt = acc_r.wdata[15:0];
            `BBM_OFS_GM: gm_nxt = acc_r.wdata;
            `BBM_OFS_BSO: bso_nxt = acc_r.wdata;
            `BBM_OFS_BSB: bsb_nxt = acc_r.wdata;
            default: begin
            end
         endcase
      end
      // Exact oscillator needs no multiplication; follows the write at once
      fac_nxt = osc_r ? 13'h0001
                      : 13'({1'b0, syn_nxt[11:0]} + 13'h0001);
   end

   // Channel-state reinit on reset command
   always_comb begin
      cp_busy_nxt = cp_busy_r;
      cp_cnt_nxt = cp_cnt_r;
      b_we = cp_busy_r;
      b_addr = 12'(`BBM_CH_BASE + cp_cnt_r);
      if (cp_busy_r) begin
         cp_cnt_nxt = 12'(cp_cnt_r + 12'h001);
         if (cp_cnt_r == `BBM_CH_LAST) begin
            cp_busy_nxt = 1'b0;
         end
      end else if (wr_int && blk_hit(acc_r.addr, mbr_r) &&
                   ofs == `BBM_OFS_CMD &&
                   acc_r.wdata[`BBM_CMD_FLG_BIT] &&
                   acc_r.wdata[`BBM_CMD_OP_LSB +: 4] ==
                   `BBM_CMD_OP_RESET) begin
         cp_busy_nxt = 1'b1;
         cp_cnt_nxt = 12'h000;
      end
   end

   // State registers
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_r <= BBM_S_SP;
         acc_r <= '0;
         mem_r <= '0;
         sp_r <= 32'h0000_0000;
         pc_r <= 32'h0000_0000;
         run_r <= 1'b0;
         done_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         intl_r <= 1'b0;
         mbr_r <= `BBM_MBR_RST;
         mbre_r <= 1'b1;
         syn_r <= `BBM_SYN_RST;
         syn_lock_r <= 1'b0;
         pa_r <= `BBM_PA_RST;
         gm_r <= `BBM_GM_RST;
         bso_r <= `BBM_BSO_RST;
         bsb_r <= `BBM_BSB_RST;
         fac_r <= 13'h0001;
         cp_busy_r <= 1'b0;
         cp_cnt_r <= 12'h000;
      end else begin
         state_r <= state_nxt;
         acc_r <= acc_nxt;
         mem_r <= mem_nxt;
         sp_r <= sp_nxt;
         pc_r <= pc_nxt;
         run_r <= run_nxt;
         done_r <= done_nxt;
         rdata_r <= rdata_nxt;
         intl_r <= intl_nxt;
         mbr_r <= mbr_nxt;
         mbre_r <= mbre_nxt;
         syn_r <= syn_nxt;
         syn_lock_r <= syn_lock_nxt;
         pa_r <= pa_nxt;
         gm_r <= gm_nxt;
         bso_r <= bso_nxt;
         bsb_r <= bsb_nxt;
         fac_r <= fac_nxt;
         cp_busy_r <= cp_busy_nxt;
         cp_cnt_r <= cp_cnt_nxt;
      end
      // Not reset by sys_rst: cause updated by cause inputs, oscillator strap loaded while sys_rst is high
      rcr_r <= rcr_nxt;
      osc_r <= osc_nxt;
   end

   // Dual-port RAM, no reset clear; port B writes zeros for channel reinit
   bbm_dpram #(
      .DEPTH(DPR_BYTES),
      .AW(12)
   ) u_dpr (
      .ref_clk(ref_clk),
      .a_en(a_en),
      .a_we(a_we),
      .a_addr(a_addr),
      .a_wdata(acc_r.wdata[7:0]),
      .a_rdata(a_q),
      .b_we(b_we),
      .b_addr(b_addr),
      .b_wdata(8'h00)
   );

   // Outputs
   assign acc_ready = (state_r == BBM_S_IDLE);
   assign acc_done = done_r;
   assign acc_rdata = rdata_r;
   assign acc_internal = intl_r;
   assign mem = mem_r;
   assign core_run = run_r;
   assign core_super = 1'b1;
   assign core_sp = sp_r;
   assign core_pc = pc_r;
   assign synth_factor = fac_r;
   assign synth_locked = syn_lock_r;
   assign pin_we_sel = pa_r[`BBM_PA_WE_BIT];
   assign cp_busy = cp_busy_r;
endmodule
`default_nettype wire

// ---- testbench/bbm_mem_model.sv ----
// Boot memory model answering the block's four-phase memory link
`timescale 1ns/1ps
`default_nettype none
module bbm_mem_model
   import bbm_pkg::*;
#(
   parameter logic [31:0] SP_V = 32'h0001_0000,
   parameter logic [31:0] PC_V = 32'h0000_0400
) (
   input wire logic ref_clk,
   input wire bbm_mem_t mem,
   input wire logic slow,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   logic [31:0] arr [16]; // Word store, address bits 5..2
   int cnt; // Wait count for slow answers
   // Vectors sit in the first two words
   initial begin
      for (int i = 0; i < 16; i++) begin
         arr[i] = {16'ha5a5, i[15:0]};
      end
      arr[0] = SP_V;
      arr[1] = PC_V;
      mem_ack = 1'b0;
      mem_rdata = 32'h0;
      cnt = 0;
   end
   // Ack after optional waits, drop when request leaves
   always @(posedge ref_clk) begin
      if (mem.req && !mem_ack) begin
         if (cnt < (slow ? 6 : 0)) begin
            cnt <= cnt + 1;
         end else begin
            cnt <= 0;
            mem_ack <= 1'b1;
            if (mem.wr) begin
               arr[mem.addr[5:2]] <= mem.wdata;
            end else begin
               mem_rdata <= arr[mem.addr[5:2]];
            end
         end
      end else if (!mem.req && mem_ack) begin
         mem_ack <= 1'b0;
         // Released bus no longer shows old data
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule
`default_nettype wire

// ---- testbench/bbm_boot_map_asserts.sv ----
// Port checker for the boot and base mapping block
`timescale 1ns/1ps
`default_nettype none
module bbm_boot_map_asserts
   import bbm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire bbm_acc_t acc,
   input wire logic acc_ready,
   input wire logic acc_done,
   input wire logic acc_internal,
   input wire bbm_mem_t mem,
   input wire logic mem_ack,
   input wire logic core_run,
   input wire logic core_super,
   input wire logic [12:0] synth_factor,
   input wire logic synth_locked,
   input wire logic cp_busy
);
   logic [11:0] busy_cnt_r; // Length of current reinit run
   logic [11:0] busy_cnt_nxt;
   // Count busy cycles, restart when idle
   always_comb begin
      busy_cnt_nxt = cp_busy ? busy_cnt_r + 12'h001 : 12'h000;
   end
   always_ff @(posedge ref_clk) begin
      busy_cnt_r <= sys_rst ? 12'h000 : busy_cnt_nxt;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   boot_fetch_a: assert property ($fell(sys_rst) |-> ##[0:1]
      (mem.req && mem.addr == 32'h0 && mem.boot_cs && mem.fc == 3'h6
      && mem.waits == 4'hf)) else $error("boot fetch not started");
   super_mode_a: assert property (core_super)
      else $error("core left supervisor state");
   one_take_a: assert property (acc.valid && acc_ready |=> !acc_ready)
      else $error("second request taken while busy");
   int_answer_a: assert property ((acc.valid && acc_ready) ##1
      acc_internal |-> !acc_done ##1 acc_done)
      else $error("internal answer late");
   done_pulse_a: assert property (acc_done |=> !acc_done)
      else $error("done longer than one cycle");
   mem_stable_a: assert property (mem.req && $past(mem.req) |->
      $stable(mem)) else $error("memory request changed");
   ack_release_a: assert property (mem.req && $rose(mem_ack) |->
      ##[2:4] !mem.req) else $error("request not released");
   req_gap_a: assert property ($fell(mem.req) |-> !mem.req [*3])
      else $error("request reissued too soon");
   lock_hold_a: assert property (synth_locked |=> synth_locked &&
      $stable(synth_factor)) else $error("locked synthesizer changed");
   reinit_len_a: assert property ($fell(cp_busy) |-> busy_cnt_r >= 767
      && busy_cnt_r <= 769) else $error("reinit length wrong");
   run_hold_a: assert property (core_run |=> core_run)
      else $error("core run dropped");
endmodule
bind bbm_boot_map bbm_boot_map_asserts chk (.ref_clk(ref_clk),
   .sys_rst(sys_rst), .acc(acc), .acc_ready(acc_ready),
   .acc_done(acc_done), .acc_internal(acc_internal), .mem(mem),
   .mem_ack(mem_ack), .core_run(core_run), .core_super(core_super),
   .synth_factor(synth_factor), .synth_locked(synth_locked),
   .cp_busy(cp_busy));
`default_nettype wire

// ---- testbench/bbm_boot_map_bench.sv ----
// Bench driving core accesses against the boot memory model
`timescale 1ns/1ps
`default_nettype none
`include "bbm_params.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
   miscompares++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module bbm_boot_map_bench;
   import bbm_pkg::*;
   logic ref_clk, sys_rst, osc_exact, slow, mem_ack, last_int;
   logic fch; // Marks the next core access as an instruction fetch
   logic acc_ready, acc_done, acc_internal, core_run, core_super;
   logic synth_locked, pin_we_sel, cp_busy;
   logic [31:0] acc_rdata, mem_rdata, core_sp, core_pc, q;
   logic [7:0] rst_cause;
   logic [12:0] synth_factor;
   bbm_acc_t acc;
   bbm_mem_t mem, seen; // seen holds latest external request
   int miscompares, num_checks;
   bbm_boot_map uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .acc(acc),
      .acc_ready(acc_ready), .acc_done(acc_done), .acc_rdata(acc_rdata),
      .acc_internal(acc_internal), .mem(mem), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .rst_cause(rst_cause), .osc_exact(osc_exact),
      .core_run(core_run), .core_super(core_super), .core_sp(core_sp),
      .core_pc(core_pc), .synth_factor(synth_factor),
      .synth_locked(synth_locked), .pin_we_sel(pin_we_sel),
      .cp_busy(cp_busy));
   bbm_mem_model mdl (.ref_clk(ref_clk), .mem(mem), .slow(slow),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Keep fields of the last external request
   always @(negedge ref_clk) begin
      if (mem.req) seen <= mem;
   end
   // Verdict and end of run
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // One bounded wait step
   task automatic tick(inout int n);
      @(negedge ref_clk);
      n++;
      if (n > 3000) begin
         miscompares++;
         final_report();
      end
   endtask
   // One core access: hold until taken, then wait for the answer
   task automatic op(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(negedge ref_clk);
      acc <= '{1'b1, w, fch, a, d};
      while (acc_ready !== 1'b1) tick(n);
      tick(n);
      acc.valid <= 1'b0;
      while (acc_done !== 1'b1) tick(n);
      q = acc_rdata;
      last_int = acc_internal;
   endtask
   // Reset for five cycles, then wait for both vectors
   task automatic do_reset(input logic osc);
      int n;
      n = 0;
      @(negedge ref_clk);
      sys_rst <= 1'b1;
      osc_exact <= osc;
      rst_cause <= 8'h01;
      repeat (5) @(negedge ref_clk);
      sys_rst <= 1'b0;
      rst_cause <= 8'h00;
      while (core_run !== 1'b1) tick(n);
   endtask
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      osc_exact = 1'b0;
      slow = 1'b0;
      fch = 1'b0;
      rst_cause = 8'h01;
      acc = '0;
      miscompares = 0;
      num_checks = 0;
      do_reset(1'b0);
      `CHK("sp", 32'h0001_0000, core_sp)
      `CHK("pc", 32'h0000_0400, core_pc)
      `CHK("super", 1'b1, core_super)
      `CHK("vec addr", 32'h4, seen.addr)
      `CHK("vec fc", `BBM_FC_SUP_PROG, seen.fc)
      // Before base is valid, internal window goes outside
      slow = 1'b1;
      op(1'b0, 32'h0070_1000, 32'h0);
      `CHK("pre int", 1'b0, last_int)
      `CHK("pre cs", 1'b1, seen.boot_cs)
      `CHK("pre waits", 4'hf, seen.waits)
      `CHK("data fc", `BBM_FC_SUP_DATA, seen.fc)
      `CHK("pre data", 32'h0001_0000, q)
      op(1'b1, `BBM_MBR_ADDR, 32'h0070_0001);
      op(1'b0, `BBM_MBR_ADDR, 32'h0);
      `CHK("base", 32'h0070_0001, q)
      // RAM bytes at the base and at the last byte
      op(1'b1, 32'h0070_09e1, 32'h5a);
      op(1'b1, 32'h0070_0000, 32'h33);
      op(1'b0, 32'h0070_0000, 32'h0);
      `CHK("ram 33", 8'h33, q[7:0])
      `CHK("ram int", 1'b1, last_int)
      op(1'b1, 32'h0070_0000, 32'hcc);
      op(1'b0, 32'h0070_0000, 32'h0);
      `CHK("ram cc", 8'hcc, q[7:0])
      // Reset cause: read, clear with ones, catch a new cause
      op(1'b0, 32'h0070_1000, 32'h0);
      `CHK("cause", 32'h1, q)
      op(1'b1, 32'h0070_1000, 32'hff);
      op(1'b0, 32'h0070_1000, 32'h0);
      `CHK("cause clr", 32'h0, q)
      @(negedge ref_clk) rst_cause <= 8'h04;
      @(negedge ref_clk) rst_cause <= 8'h00;
      op(1'b0, 32'h0070_1000, 32'h0);
      `CHK("cause new", 32'h4, q)
      // Synthesizer factor, then lock
      op(1'b1, 32'h0070_1004, 32'ha);
      `CHK("factor", 13'h00b, synth_factor)
      op(1'b1, 32'h0070_1004, 32'h8000);
      `CHK("locked", 1'b1, synth_locked)
      op(1'b1, 32'h0070_1004, 32'h5);
      op(1'b0, 32'h0070_1004, 32'h0);
      `CHK("lock val", 32'h8000, q)
      `CHK("lock fac", 13'h001, synth_factor)
      // Pin assignment both ways
      op(1'b1, 32'h0070_1008, 32'h80);
      `CHK("we sel", 1'b1, pin_we_sel)
      op(1'b1, 32'h0070_1008, 32'h0);
      `CHK("addr sel", 1'b0, pin_we_sel)
      op(1'b0, 32'h0070_1ffc, 32'h0);
      `CHK("unmapped", 32'h0, q)
      // Remap boot select, valid bit last
      op(1'b1, 32'h0070_100c, 32'h0);
      op(1'b1, 32'h0070_1010, 32'hffff_0002);
      op(1'b1, 32'h0070_1014, 32'h0000_0001);
      fch = 1'b1;
      op(1'b0, 32'h0000_0008, 32'h0);
      fch = 1'b0;
      `CHK("fetch fc", `BBM_FC_SUP_PROG, seen.fc)
      `CHK("cs hit", 1'b1, seen.boot_cs)
      `CHK("cs waits", 4'h2, seen.waits)
      `CHK("ext data", 32'ha5a5_0002, q)
      op(1'b0, 32'h0010_0000, 32'h0);
      `CHK("cs miss", 1'b0, seen.boot_cs)
      // External memory: settle time and dummy reads, then write
      repeat (10000) @(negedge ref_clk);
      repeat (8) op(1'b0, 32'h0010_0010, 32'h0);
      op(1'b1, 32'h0010_0010, 32'h1234_5678);
      `CHK("ext wr", 1'b1, seen.wr)
      `CHK("ext wdata", 32'h1234_5678, seen.wdata)
      op(1'b0, 32'h0010_0010, 32'h0);
      `CHK("ext back", 32'h1234_5678, q)
      // Channel reinit clears parameter bytes only
      op(1'b1, 32'h0070_1018, 32'h1);
      `CHK("busy", 1'b1, cp_busy)
      begin
         int n;
         n = 0;
         while (cp_busy !== 1'b0) tick(n);
      end
      op(1'b0, 32'h0070_09e1, 32'h0);
      `CHK("prm clr", 8'h00, q[7:0])
      op(1'b0, 32'h0070_0000, 32'h0);
      `CHK("sys kept", 8'hcc, q[7:0])
      // Base write refused when enable is off
      op(1'b1, `BBM_MBRE_ADDR, 32'h0);
      op(1'b1, `BBM_MBR_ADDR, 32'h0080_0001);
      op(1'b0, 32'h0070_0000, 32'h0);
      `CHK("base kept", 1'b1, last_int)
      // Second reset: RAM kept, strap bypasses multiply
      slow = 1'b0;
      do_reset(1'b1);
      `CHK("unlock", 1'b0, synth_locked)
      op(1'b0, 32'h0070_0000, 32'h0);
      `CHK("post int", 1'b0, last_int)
      op(1'b1, `BBM_MBR_ADDR, 32'h0070_0001);
      op(1'b0, 32'h0070_0000, 32'h0);
      `CHK("ram kept", 8'hcc, q[7:0])
      op(1'b1, 32'h0070_1004, 32'ha);
      `CHK("bypass", 13'h001, synth_factor)
      final_report();
   end
endmodule
`default_nettype wire
